// ### hdl/cpfd_top.sv
// Control port frame decoder: byte link crossing, header parse, burst write and read
`timescale 1ns/1ps
// How it works
// - Data fields travel as whole bytes, zero padded above their MSB.
// - A 28-bit parameter word travels as four bytes, top nibble zero.
// - A 40-bit program word travels as exactly five bytes.
// - Header is chip address with read flag, then two address bytes.
// - Byte count per location comes from the decoded address, plus the read flag for capture registers.
// - Single writes span four bytes up to eight bytes in total.
// - Continued words in a burst go to previous address plus one.
// - Burst crosses region boundaries; byte count follows the new region.
// - Parameter header: six zeros, address 9:8, then address 7:0.
// - Parameter data: four zeros, bits 27:24, then bits 23:0.
// - Program header: five zeros, address 10:8, then five bytes MSB first.
// - Core and serial output registers take two bytes, upper first.
// - RAM config and serial input registers take one data byte.
// - Capture write: three zeros, 11-bit count, 2-bit select at bottom.
// - Select picks one of four sources captured on program count match.
// - Capture register read returns three bytes of the 24-bit value.
// - Safeload address write: six zeros with bits 9:8, then bits 7:0.
// - Safeload data write: zero byte, nibble with 27:24, then 23:0.
// - Five safeload pairs copy into parameter RAM while it is idle.
// - 0..1023 is parameter RAM, 1024..2047 program RAM, registers above.
module cpfd_top #(
  parameter logic [6:0] CHIP_ADDR = 7'h34
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic LINK_CLK_I,
  input wire logic LINK_BYTE_VLD_I,
  input wire logic [7:0] LINK_BYTE_I,
  input wire logic LINK_FRAME_END_I,
  input wire logic LINK_TX_TAKE_I,
  output logic LINK_TX_VLD_O,
  output logic [7:0] LINK_TX_BYTE_O,
  output logic WR_VLD_O,
  output cpfd_pkg::cpfd_wr_t WR_O,
  output logic RD_REQ_O,
  output logic [11:0] RD_ADDR_O,
  input wire logic RD_ACK_I,
  input wire logic [39:0] RD_DATA_I,
  input wire logic CORE_RAM_BUSY_I,
  input wire logic [10:0] CORE_PC_I,
  input wire cpfd_pkg::cpfd_cap_src_t CAP_SRC_I
);
  import cpfd_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR_HI = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDREQ = 3'b100,
    ST_RDWAIT = 3'b101,
    ST_SEND = 3'b110,
    ST_DROP = 3'b111
  } cpfd_state_t;

  // Bytes a location occupies, from its address and, for capture registers, the read flag
  function automatic logic [2:0] bytes_for(input logic [11:0] a, input logic rd);
    logic [2:0] n;
    n = NB_HALF;
    if (a <= PARAM_LAST) begin
      n = NB_PARAM;
    end else if (a <= PROG_LAST) begin
      n = NB_PROG;
    end else if (a <= IFACE_LAST) begin
      n = NB_IFACE;
    end else if (a >= GPIO_ADDR && a <= AUX_LAST) begin
      n = NB_HALF;
    end else if (a > AUX_LAST && a <= SLDATA_LAST) begin
      n = NB_WIDE;
    end else if (a >= SLADDR_BASE && a <= SLADDR_LAST) begin
      n = NB_HALF;
    end else if (a == CAP0_ADDR || a == CAP1_ADDR) begin
      n = rd ? NB_CAP_RD : NB_HALF;
    end else if (a == RAM_CFG_ADDR || a == SIN_ADDR) begin
      n = NB_BYTE;
    end else begin
      n = NB_HALF;
    end
    return n;
  endfunction

  // ---------------- Link domain ----------------
  logic [7:0] rx_byte_q;
  logic rx_tgl_q;
  logic end_tgl_q;
  logic ack_tgl_q;
  logic tx_s1_q;
  logic tx_s2_q;
  logic tx_seen_q;
  logic frame_open_q;
  logic tx_tgl_q;
  logic [7:0] tx_byte_q;

  // Byte and frame end events become toggles; the byte stays still until the next one
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_byte_q <= BYTE_RST;
      rx_tgl_q <= 1'b0;
      end_tgl_q <= 1'b0;
    end else begin
      if (LINK_BYTE_VLD_I) begin
        rx_byte_q <= LINK_BYTE_I;
        rx_tgl_q <= ~rx_tgl_q;
      end
      if (LINK_FRAME_END_I) begin
        end_tgl_q <= ~end_tgl_q;
      end
    end
  end

  // Read bytes handed over from the core side, held until the link takes them or the frame ends
  // A byte fetched ahead of a frame end is dropped and still acknowledged,
  // so it cannot linger into the next frame or leave the core waiting
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_s1_q <= 1'b0;
      tx_s2_q <= 1'b0;
      tx_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      frame_open_q <= 1'b0;
      LINK_TX_VLD_O <= 1'b0;
      LINK_TX_BYTE_O <= BYTE_RST;
    end else begin
      tx_s1_q <= tx_tgl_q;
      tx_s2_q <= tx_s1_q;
      if (LINK_FRAME_END_I) begin
        frame_open_q <= 1'b0;
      end else if (LINK_BYTE_VLD_I) begin
        frame_open_q <= 1'b1;
      end
      if (tx_s2_q != tx_seen_q) begin
        tx_seen_q <= tx_s2_q;
        if (frame_open_q && !LINK_FRAME_END_I) begin
          LINK_TX_BYTE_O <= tx_byte_q;
          LINK_TX_VLD_O <= 1'b1;
        end else begin
          ack_tgl_q <= ~ack_tgl_q;
        end
      end else if (LINK_TX_VLD_O && (LINK_TX_TAKE_I || LINK_FRAME_END_I)) begin
        LINK_TX_VLD_O <= 1'b0;
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  // ---------------- Core domain ----------------
  logic [2:0] rx_sync_q;
  logic [2:0] end_sync_q;
  logic [2:0] ack_sync_q;
  logic rx_evt;
  logic end_evt;
  logic ack_evt;

  // Two flops per toggle, the third only feeds the edge compare
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_sync_q <= 3'h0;
      end_sync_q <= 3'h0;
      ack_sync_q <= 3'h0;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_tgl_q};
      end_sync_q <= {end_sync_q[1:0], end_tgl_q};
      ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
    end
  end

  assign rx_evt = rx_sync_q[2] ^ rx_sync_q[1];
  assign end_evt = end_sync_q[2] ^ end_sync_q[1];
  assign ack_evt = ack_sync_q[2] ^ ack_sync_q[1];

  cpfd_state_t state_q;
  logic rd_q;
  logic [11:0] addr_q;
  logic [2:0] cnt_q;
  logic [2:0] need;
  logic [39:0] word_q;
  logic [39:0] word_d;
  logic tx_busy_q;
  logic [39:0] rd_word;
  logic [10:0] cap_pc_q [2];
  logic [1:0] cap_sel_q [2];
  logic [23:0] cap_val_q [2];
  logic [9:0] sl_addr_q [SL_SLOTS];
  logic [27:0] sl_data_q [SL_SLOTS];
  logic [SL_SLOTS-1:0] sl_pend_q;
  logic host_wr;
  logic [SL_SLOTS-1:0] sl_data_hit;
  logic [SL_SLOTS-1:0] sl_addr_hit;
  logic sl_go;
  logic [2:0] sl_idx;

  assign need = bytes_for(addr_q, rd_q);
  assign word_d = {word_q[31:0], rx_byte_q};
  assign host_wr = (state_q == ST_WDATA) && rx_evt && (cnt_q == need - 3'h1);
  // Captured value for a read is chosen by comparing the address with CAP1_ADDR
  assign rd_word = {16'h0000, cap_val_q[addr_q == CAP1_ADDR]};

  // Frame parse: header, then words whose size follows the running address
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
      rd_q <= 1'b0;
      addr_q <= ADDR_RST;
      cnt_q <= 3'h0;
      word_q <= WORD_RST;
      tx_busy_q <= 1'b0;
      tx_tgl_q <= 1'b0;
      tx_byte_q <= BYTE_RST;
      RD_REQ_O <= 1'b0;
      RD_ADDR_O <= ADDR_RST;
    end else begin
      RD_REQ_O <= 1'b0;
      if (ack_evt) begin
        tx_busy_q <= 1'b0;
      end
      if (end_evt) begin
        state_q <= ST_IDLE;
        cnt_q <= 3'h0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (rx_evt) begin
              rd_q <= rx_byte_q[0];
              state_q <= (rx_byte_q[7:1] == CHIP_ADDR) ? ST_ADDR_HI : ST_DROP;
            end
          end
          ST_ADDR_HI: begin
            if (rx_evt) begin
              addr_q <= {rx_byte_q[3:0], 8'h00};
              state_q <= ST_ADDR_LO;
            end
          end
          ST_ADDR_LO: begin
            if (rx_evt) begin
              addr_q <= {addr_q[11:8], rx_byte_q};
              cnt_q <= 3'h0;
              word_q <= WORD_RST;
              state_q <= rd_q ? ST_RDREQ : ST_WDATA;
            end
          end
          ST_WDATA: begin
            if (rx_evt) begin
              // Each word starts from zero so short words keep their padding
              if (cnt_q == need - 3'h1) begin
                word_q <= WORD_RST;
                cnt_q <= 3'h0;
                addr_q <= addr_q + 12'h001;
              end else begin
                word_q <= word_d;
                cnt_q <= cnt_q + 3'h1;
              end
            end
          end
          ST_RDREQ: begin
            if (addr_q == CAP0_ADDR || addr_q == CAP1_ADDR) begin
              word_q <= rd_word << (8 * (5 - need));
              state_q <= ST_SEND;
            end else begin
              RD_REQ_O <= 1'b1;
              RD_ADDR_O <= addr_q;
              state_q <= ST_RDWAIT;
            end
          end
          ST_RDWAIT: begin
            if (RD_ACK_I) begin
              word_q <= RD_DATA_I << (8 * (5 - need));
              state_q <= ST_SEND;
            end
          end
          ST_SEND: begin
            // One byte in flight at a time; the link acknowledges before the next
            if (!tx_busy_q && !ack_evt) begin
              tx_byte_q <= word_q[39:32];
              tx_tgl_q <= ~tx_tgl_q;
              tx_busy_q <= 1'b1;
              word_q <= {word_q[31:0], 8'h00};
              if (cnt_q == need - 3'h1) begin
                cnt_q <= 3'h0;
                addr_q <= addr_q + 12'h001;
                state_q <= ST_RDREQ;
              end else begin
                cnt_q <= cnt_q + 3'h1;
              end
            end
          end
          ST_DROP: begin
            state_q <= ST_DROP; // Not our chip: ignore bytes until frame end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Slot decode for safeload registers
  genvar gi;
  generate
    for (gi = 0; gi < SL_SLOTS; gi++) begin : g_sl
      assign sl_data_hit[gi] = host_wr && (addr_q == SLDATA_BASE + 12'(gi));
      assign sl_addr_hit[gi] = host_wr && (addr_q == SLADDR_BASE + 12'(gi));

      // A new data write re-arms the slot even if it was copied this cycle
      always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          sl_addr_q[gi] <= 10'h000;
          sl_data_q[gi] <= 28'h000_0000;
          sl_pend_q[gi] <= 1'b0;
        end else begin
          if (sl_addr_hit[gi]) begin
            sl_addr_q[gi] <= word_d[9:0];
          end
          if (sl_data_hit[gi]) begin
            sl_data_q[gi] <= word_d[27:0];
            sl_pend_q[gi] <= 1'b1;
          end else if (sl_go && sl_idx == 3'(gi)) begin
            sl_pend_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Lowest pending slot goes first; host writes take the port ahead of it
  always_comb begin
    sl_idx = 3'h0;
    for (int k = SL_SLOTS - 1; k >= 0; k--) begin
      if (sl_pend_q[k]) begin
        sl_idx = 3'(k);
      end
    end
  end
  assign sl_go = (|sl_pend_q) && !CORE_RAM_BUSY_I && !host_wr;

  // Write port to RAMs and registers outside this block
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      WR_VLD_O <= 1'b0;
      WR_O <= '0;
    end else begin
      WR_VLD_O <= host_wr || sl_go;
      if (host_wr) begin
        WR_O <= '{addr: addr_q, data: word_d};
      end else if (sl_go) begin
        WR_O <= '{addr: {2'b00, sl_addr_q[sl_idx]}, data: {12'h000, sl_data_q[sl_idx]}};
      end
    end
  end

  // Capture setup and program count match
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          cap_pc_q[gi] <= 11'h000;
          cap_sel_q[gi] <= 2'h0;
          cap_val_q[gi] <= 24'h00_0000;
        end else begin
          if (host_wr && addr_q == CAP0_ADDR + 12'(gi)) begin
            cap_pc_q[gi] <= word_d[CAP_PC_LSB +: 11];
            cap_sel_q[gi] <= word_d[CAP_SEL_LSB +: 2];
          end
          if (CORE_PC_I == cap_pc_q[gi]) begin
            case (cap_sel_q[gi])
              2'h0: cap_val_q[gi] <= CAP_SRC_I.src0;
              2'h1: cap_val_q[gi] <= CAP_SRC_I.src1;
              2'h2: cap_val_q[gi] <= CAP_SRC_I.src2;
              default: cap_val_q[gi] <= CAP_SRC_I.src3;
            endcase
          end
        end
      end
    end
  endgenerate
endmodule // cpfd_top

// ### shared/cpfd_pkg.sv
// Constants and carrier types for the control port frame decoder
package cpfd_pkg;
  // Address map boundaries
  localparam logic [11:0] PARAM_LAST = 12'h03FF;
  localparam logic [11:0] PROG_LAST = 12'h07FF;
  localparam logic [11:0] IFACE_LAST = 12'h0807;
  localparam logic [11:0] GPIO_ADDR = 12'h0808;
  localparam logic [11:0] AUX_LAST = 12'h080C;
  localparam logic [11:0] SLDATA_BASE = 12'h0810;
  localparam logic [11:0] SLDATA_LAST = 12'h0814;
  localparam logic [11:0] SLADDR_BASE = 12'h0815;
  localparam logic [11:0] SLADDR_LAST = 12'h0819;
  localparam logic [11:0] CAP0_ADDR = 12'h081A;
  localparam logic [11:0] CAP1_ADDR = 12'h081B;
  localparam logic [11:0] CORE_CTRL_ADDR = 12'h081C;
  localparam logic [11:0] RAM_CFG_ADDR = 12'h081D;
  localparam logic [11:0] SOUT0_ADDR = 12'h081E;
  localparam logic [11:0] SOUT1_ADDR = 12'h081F;
  localparam logic [11:0] SIN_ADDR = 12'h0820;
  // Bytes per location
  localparam logic [2:0] NB_PARAM = 3'h4;
  localparam logic [2:0] NB_PROG = 3'h5;
  localparam logic [2:0] NB_WIDE = 3'h5;
  localparam logic [2:0] NB_IFACE = 3'h4;
  localparam logic [2:0] NB_HALF = 3'h2;
  localparam logic [2:0] NB_BYTE = 3'h1;
  localparam logic [2:0] NB_CAP_RD = 3'h3;
  // Safeload slots
  localparam int SL_SLOTS = 5;
  // Field positions inside a capture register write word
  localparam int CAP_SEL_LSB = 0;
  localparam int CAP_PC_LSB = 2;
  // Reset values
  localparam logic [39:0] WORD_RST = 40'h00_0000_0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [11:0] ADDR_RST = 12'h000;

  typedef struct packed {
    logic [11:0] addr;
    logic [39:0] data;
  } cpfd_wr_t;

  typedef struct packed {
    logic [23:0] src3;
    logic [23:0] src2;
    logic [23:0] src1;
    logic [23:0] src0;
  } cpfd_cap_src_t;
endpackage

// ### verification/cpfd_assertions.sv
// Port-level assertions for the control port frame decoder
`timescale 1ns/1ps
module cpfd_checker
  import cpfd_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic LINK_CLK_I,
  input wire logic LINK_BYTE_VLD_I,
  input wire logic [7:0] LINK_BYTE_I,
  input wire logic LINK_FRAME_END_I,
  input wire logic LINK_TX_TAKE_I,
  input wire logic LINK_TX_VLD_O,
  input wire logic [7:0] LINK_TX_BYTE_O,
  input wire logic WR_VLD_O,
  input wire cpfd_pkg::cpfd_wr_t WR_O,
  input wire logic RD_REQ_O,
  input wire logic [11:0] RD_ADDR_O,
  input wire logic RD_ACK_I,
  input wire logic [39:0] RD_DATA_I,
  input wire logic CORE_RAM_BUSY_I,
  input wire logic [10:0] CORE_PC_I,
  input wire cpfd_pkg::cpfd_cap_src_t CAP_SRC_I
);
  // Short views of the write port
  wire logic [11:0] wa = WR_O.addr;
  wire logic [39:0] wd = WR_O.data;
  // A waiting read byte is only withdrawn by the host taking it or by a frame end
  sequence s_offer;
    LINK_TX_VLD_O && !LINK_TX_TAKE_I && !LINK_FRAME_END_I;
  endsequence
  property p_tx_hold;
    @(posedge LINK_CLK_I) disable iff (!RSTN_I)
    s_offer |=> LINK_TX_VLD_O && $stable(LINK_TX_BYTE_O);
  endproperty
  property p_param_pad;
    @(posedge MCLK_I) disable iff (!RSTN_I) WR_VLD_O && wa <= PARAM_LAST |-> wd[39:28] == 12'h000;
  endproperty
  property p_half;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    WR_VLD_O && (wa == CORE_CTRL_ADDR || wa == SOUT0_ADDR) |-> wd[39:16] == 24'h00_0000;
  endproperty
  property p_byte;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    WR_VLD_O && (wa == RAM_CFG_ADDR || wa == SIN_ADDR) |-> wd[39:8] == 32'h0000_0000;
  endproperty
  property p_cap_wr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    WR_VLD_O && (wa == CAP0_ADDR || wa == CAP1_ADDR) |-> wd[39:13] == 27'h000_0000;
  endproperty
  property p_sl_addr;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    WR_VLD_O && wa >= SLADDR_BASE && wa <= SLADDR_LAST |-> wd[39:10] == 30'h0000_0000;
  endproperty
  property p_sl_data;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    WR_VLD_O && wa >= SLDATA_BASE && wa <= SLDATA_LAST |-> wd[39:28] == 12'h000;
  endproperty
  property p_rd_pulse;
    @(posedge MCLK_I) disable iff (!RSTN_I) RD_REQ_O |=> !RD_REQ_O;
  endproperty
  property p_rd_hold;
    @(posedge MCLK_I) disable iff (!RSTN_I) !RD_REQ_O |-> $stable(RD_ADDR_O);
  endproperty
  property p_rd_no_cap;
    @(posedge MCLK_I) disable iff (!RSTN_I)
    RD_REQ_O |-> RD_ADDR_O != CAP0_ADDR && RD_ADDR_O != CAP1_ADDR;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("read byte withdrawn early");
  a_param_pad: assert property (p_param_pad) else $error("param word not padded");
  a_half: assert property (p_half) else $error("two byte register too wide");
  a_byte: assert property (p_byte) else $error("one byte register too wide");
  a_cap_wr: assert property (p_cap_wr) else $error("capture write too wide");
  a_sl_addr: assert property (p_sl_addr) else $error("safeload address too wide");
  a_sl_data: assert property (p_sl_data) else $error("safeload data too wide");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request not a pulse");
  a_rd_hold: assert property (p_rd_hold) else $error("read address moved");
  a_rd_no_cap: assert property (p_rd_no_cap) else $error("capture read left core");
endmodule // cpfd_checker

bind cpfd_top cpfd_checker u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .LINK_CLK_I(LINK_CLK_I),
  .LINK_BYTE_VLD_I(LINK_BYTE_VLD_I), .LINK_BYTE_I(LINK_BYTE_I),
  .LINK_FRAME_END_I(LINK_FRAME_END_I), .LINK_TX_TAKE_I(LINK_TX_TAKE_I),
  .LINK_TX_VLD_O(LINK_TX_VLD_O), .LINK_TX_BYTE_O(LINK_TX_BYTE_O), .WR_VLD_O(WR_VLD_O),
  .WR_O(WR_O), .RD_REQ_O(RD_REQ_O), .RD_ADDR_O(RD_ADDR_O), .RD_ACK_I(RD_ACK_I),
  .RD_DATA_I(RD_DATA_I), .CORE_RAM_BUSY_I(CORE_RAM_BUSY_I), .CORE_PC_I(CORE_PC_I),
  .CAP_SRC_I(CAP_SRC_I));

// ### verification/cpfd_host_model.sv
// Behavioural control port master on the byte link
`timescale 1ns/1ps
module cpfd_host_model (
  output logic lclk,
  output logic vld,
  output logic [7:0] byte_o,
  output logic fend,
  output logic take,
  input wire logic tx_vld,
  input wire logic [7:0] tx_byte
);
  logic run;
  initial begin
    run = 1'b1;
    lclk = 1'b0;
    vld = 1'b0;
    byte_o = 8'h00;
    fend = 1'b0;
    take = 1'b0;
  end
  // Link clock parks low between frames
  always begin
    #7.5;
    lclk = run ? ~lclk : 1'b0;
  end
  // Six idle link cycles per byte leave the core time to catch each one
  task automatic send(input logic [7:0] b);
    run = 1'b1;
    @(negedge lclk);
    vld = 1'b1;
    byte_o = b;
    @(negedge lclk);
    vld = 1'b0;
    byte_o = ~b;
    repeat (6) @(negedge lclk);
  endtask
  // A one-cycle frame end pulse ends the transaction, then the link clock parks
  task automatic close();
    @(negedge lclk);
    fend = 1'b1;
    @(negedge lclk);
    fend = 1'b0;
    repeat (4) @(negedge lclk);
    run = 1'b0;
  endtask
  // Wait for an offered read byte and acknowledge it
  task automatic recv(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    do begin
      @(posedge lclk);
      n++;
    end while (tx_vld !== 1'b1 && n < 300);
    ok = (tx_vld === 1'b1);
    b = tx_byte;
    @(negedge lclk);
    take = 1'b1;
    @(negedge lclk);
    take = 1'b0;
    repeat (2) @(negedge lclk);
  endtask
endmodule // cpfd_host_model

// ### verification/tb_cpfd_top.sv
// Self-checking bench for the control port frame decoder
`timescale 1ns/1ps
module tb_cpfd_top;
  import cpfd_pkg::*;
  logic MCLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic RD_ACK_I = 1'b0;
  logic CORE_RAM_BUSY_I = 1'b0;
  logic [39:0] RD_DATA_I = 40'h00_0000_0000;
  logic [10:0] CORE_PC_I = 11'h000;
  cpfd_cap_src_t CAP_SRC_I = {24'h33_3333, 24'hC0_FFEE, 24'h11_1111, 24'h00_0001};
  wire logic lclk, lvld, fend, take, tx_vld;
  wire logic [7:0] lbyte, tx_byte;
  logic WR_VLD_O, RD_REQ_O;
  cpfd_wr_t WR_O;
  logic [11:0] RD_ADDR_O, last_ra;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  cpfd_wr_t wq[$];

  cpfd_top dut (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .LINK_CLK_I(lclk), .LINK_BYTE_VLD_I(lvld),
    .LINK_BYTE_I(lbyte), .LINK_FRAME_END_I(fend), .LINK_TX_TAKE_I(take),
    .LINK_TX_VLD_O(tx_vld), .LINK_TX_BYTE_O(tx_byte), .WR_VLD_O(WR_VLD_O), .WR_O(WR_O),
    .RD_REQ_O(RD_REQ_O), .RD_ADDR_O(RD_ADDR_O), .RD_ACK_I(RD_ACK_I), .RD_DATA_I(RD_DATA_I),
    .CORE_RAM_BUSY_I(CORE_RAM_BUSY_I), .CORE_PC_I(CORE_PC_I), .CAP_SRC_I(CAP_SRC_I));
  cpfd_host_model h (.lclk(lclk), .vld(lvld), .byte_o(lbyte), .fend(fend), .take(take),
    .tx_vld(tx_vld), .tx_byte(tx_byte));

  always #4 MCLK_I = ~MCLK_I;

  function automatic logic [39:0] rdv(input logic [11:0] a);
    return {12'h000, 16'hA5C3, a};
  endfunction

  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Collect issued writes; the cycle ceiling cuts a hang short
  always @(posedge MCLK_I) begin
    if (WR_VLD_O === 1'b1) wq.push_back(WR_O);
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end
  // Core read port answers one cycle after each request
  always @(posedge MCLK_I) begin
    if (RD_REQ_O === 1'b1) begin
      last_ra = RD_ADDR_O;
      @(negedge MCLK_I);
      RD_ACK_I = 1'b1;
      RD_DATA_I = rdv(last_ra);
      @(negedge MCLK_I);
      RD_ACK_I = 1'b0;
      RD_DATA_I = ~RD_DATA_I;
    end
  end

  task automatic chk_wr(input logic [11:0] a, input logic [39:0] d);
    int n;
    n = 0;
    while (wq.size() == 0 && n < 400) begin
      @(negedge MCLK_I);
      n++;
    end
    compares++;
    if (wq.size() == 0 || wq[0] !== {a, d}) begin
      errors++;
      $display("CHECK FAILED %0t write to %h", $time, a);
    end
    if (wq.size() != 0) void'(wq.pop_front());
  endtask
  task automatic chk_byte(input logic [7:0] exp);
    logic [7:0] b;
    bit ok;
    h.recv(b, ok);
    compares++;
    if (!ok || b !== exp) begin
      errors++;
      $display("CHECK FAILED %0t read byte %h", $time, exp);
    end
  endtask
  task automatic chk_idle();
    repeat (100) @(negedge MCLK_I);
    compares++;
    if (wq.size() != 0) begin
      errors++;
      $display("CHECK FAILED %0t unexpected write", $time);
    end
  endtask
  task automatic frame(input logic [7:0] q[$], input bit end_it);
    foreach (q[i]) h.send(q[i]);
    if (end_it) h.close();
  endtask

  // Burst across the parameter to program boundary
  task automatic t_burst();
    frame('{8'h68, 8'h03, 8'hFE, 8'h01, 8'h23, 8'h45, 8'h67, 8'h0F, 8'hED, 8'hCB, 8'hA9,
      8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 1);
    chk_wr(12'h3FE, 40'h00_0123_4567);
    chk_wr(12'h3FF, 40'h00_0FED_CBA9);
    chk_wr(12'h400, 40'h11_2233_4455);
  endtask
  // Two byte then one byte registers in one burst
  task automatic t_regs();
    frame('{8'h68, 8'h08, 8'h1C, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A}, 1);
    chk_wr(12'h81C, 40'h00_0000_1234);
    chk_wr(12'h81D, 40'h00_0000_0056);
    chk_wr(12'h81E, 40'h00_0000_789A);
    frame('{8'h6A, 8'h00, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44}, 1);
    chk_idle();
  endtask
  // Burst read of two parameter words
  task automatic t_read();
    logic [39:0] v;
    frame('{8'h69, 8'h00, 8'h05}, 0);
    for (int k = 5; k < 7; k++) begin
      v = rdv(k[11:0]);
      for (int j = 3; j >= 0; j--) chk_byte(v[j*8+:8]);
    end
    h.close();
  endtask
  // Capture arms on a program count, holds, and reads back as three bytes
  task automatic t_capture();
    frame('{8'h68, 8'h08, 8'h1A, 8'h04, 8'h8E}, 1);
    chk_wr(12'h81A, 40'h00_0000_048E);
    @(negedge MCLK_I);
    CORE_PC_I = 11'h123;
    repeat (4) @(negedge MCLK_I);
    CORE_PC_I = 11'h000;
    CAP_SRC_I.src2 = 24'h22_2222;
    frame('{8'h69, 8'h08, 8'h1A}, 0);
    chk_byte(8'hC0);
    chk_byte(8'hFF);
    chk_byte(8'hEE);
    h.close();
  endtask
  // Safeload copy waits for the core to free parameter RAM
  task automatic t_safeload();
    @(negedge MCLK_I);
    CORE_RAM_BUSY_I = 1'b1;
    frame('{8'h68, 8'h08, 8'h15, 8'h01, 8'h23}, 1);
    chk_wr(12'h815, 40'h00_0000_0123);
    frame('{8'h68, 8'h08, 8'h10, 8'h00, 8'h0A, 8'hBC, 8'hDE, 8'hF1}, 1);
    chk_wr(12'h810, 40'h00_0ABC_DEF1);
    chk_idle();
    CORE_RAM_BUSY_I = 1'b0;
    chk_wr(12'h123, 40'h00_0ABC_DEF1);
  endtask

  // Reset spans at least two edges of both clocks
  initial begin
    repeat (4) @(negedge MCLK_I);
    RSTN_I = 1'b1;
    repeat (4) @(negedge MCLK_I);
    t_burst();
    t_regs();
    t_read();
    t_capture();
    t_safeload();
    give_verdict();
  end
endmodule // tb_cpfd_top
